// *** dv/mrx_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Memory on the far side of the request port.
module mrx_mem_model
(
    input wire logic clk,
    input wire logic [3:0] lat,
    input wire mrx_pkg::mrx_mem_req_t mem_req,
    output mrx_pkg::mrx_mem_rsp_t mem_rsp
);
    logic [11:0] mem [0:4095];
    logic [3:0] wait_r = 4'h0;
    logic [11:0] last_r = 12'h000;
    // Acknowledge after lat wait cycles; undriven data is the inverse of the last word.
    always_comb
    begin
        mem_rsp.ack = mem_req.valid && (wait_r >= lat);
        mem_rsp.rdata = (mem_rsp.ack && !mem_req.write) ? mem[mem_req.addr] : ~last_r;
    end
    // Count waits, store written words and remember the last word read.
    always @(posedge clk)
    begin
        if (mem_rsp.ack || !mem_req.valid)
            wait_r <= 4'h0;
        else
            wait_r <= wait_r + 4'h1;
        if (mem_rsp.ack && mem_req.write)
            mem[mem_req.addr] <= mem_req.wdata;
        if (mem_rsp.ack && !mem_req.write)
            last_r <= mem[mem_req.addr];
    end
endmodule : mrx_mem_model
`default_nettype wire

// *** dv/mrx_mem_ref_exec_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the memory reference executor.
module mrx_mem_ref_exec_test;
    typedef struct packed {
        logic [11:0] ins;
        logic [11:0] pv;
        logic [11:0] ov;
        logic [12:0] ac;
        logic rnd;
    } mrx_case_t;
    logic clk = 1'b0;
    logic srst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [3:0] lat;
    logic [11:0] nxt;
    logic v_prev = 1'b0;
    logic a_prev = 1'b0;
    logic [31:0] seed = 32'h2531BFED;
    mrx_pkg::mrx_mem_req_t mem_req;
    mrx_pkg::mrx_mem_rsp_t mem_rsp;
    mrx_case_t tbl [14];
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0 = -1;
    int t1 = -1;
    int k;
    int m;
    mrx_mem_ref_exec mrx_mem_ref_exec_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp));
    mrx_mem_model mrx_mem_model_i (.clk(clk), .lat(lat), .mem_req(mem_req), .mem_rsp(mem_rsp));
    // Clock at 40 MHz.
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // Stamp the first read of the instruction slot and of its successor.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (mem_req.valid && !mem_req.write && (!v_prev || a_prev))
        begin
            if (mem_req.addr == 12'h080 && t0 < 0)
                t0 <= cyc;
            if (mem_req.addr == nxt && t1 < 0 && t0 >= 0)
                t1 <= cyc;
        end
        v_prev <= mem_req.valid;
        a_prev <= mem_rsp.ack;
    end
    function automatic logic [31:0] rnd32();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd32
    // States taken by an instruction word.
    function automatic int exp_n(input logic [11:0] w);
        int b;
        b = (w[11:9] == 3'h2) ? 16 : (w[11:9] == 3'h3 || w[11:9] == 3'h4) ? 11 : 10;
        if (w[11:9] == 3'h6)
            return 17;
        if (w[11:9] == 3'h7)
            return (!w[8] && w[3:1] != 3'h0) ? 15 : 10;
        if (w[8])
            b = b + ((!w[7] && w[6:3] == 4'h1) ? 6 : 5);
        return b;
    endfunction : exp_n
    // Link and accumulator after the instruction.
    function automatic logic [12:0] exp_acl(input logic [11:0] w, input logic [12:0] a,
        input logic [11:0] v);
        logic [12:0] s;
        s = {1'b0, a[11:0]} + {1'b0, v};
        case (w[11:9])
            3'h0: return {a[12], a[11:0] & v};
            3'h1: return {a[12] ^ s[12], s[11:0]};
            3'h3: return {a[12], 12'h000};
            default: return a;
        endcase
    endfunction : exp_acl
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic hang();
        fails++;
        end_of_test();
    endtask : hang
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; read data and error land in rd and err.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge clk);
        if (i == 20)
            hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Run one instruction at 0x080, halt on a jump-to-self, then compare.
    task automatic run_case(input int n);
        mrx_case_t c;
        logic [11:0] da, ea, pv, em;
        logic [12:0] acl, eacl;
        logic [2:0] op;
        logic ind;
        int i;
        c = tbl[n];
        op = c.ins[11:9];
        ind = c.ins[8] && op < 3'h6;
        da = {c.ins[7] ? 5'h01 : 5'h00, c.ins[6:0]};
        pv = (ind && da[11:3] == 9'h001) ? c.pv + 12'h001 : c.pv;
        ea = ind ? pv : da;
        r = rnd32();
        acl = c.rnd ? r[12:0] : c.ac;
        nxt = (op == 3'h4) ? ea + 12'h001 : (op == 3'h5) ? ea : 12'h081;
        nxt = (op == 3'h2 && c.ov == 12'hFFF) ? 12'h082 : nxt;
        em = (op == 3'h2) ? c.ov + 12'h001 : (op == 3'h3) ? acl[11:0] : c.ov;
        em = (op == 3'h4) ? 12'h081 : em;
        em = (op == 3'h5) ? {5'h15, nxt[6:0]} : em;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 4096; i++)
        begin
            r = rnd32();
            mrx_mem_model_i.mem[i] = r[11:0];
        end
        mrx_mem_model_i.mem[12'h080] = c.ins;
        if (ind)
            mrx_mem_model_i.mem[da] = c.pv;
        if (op < 3'h6)
            mrx_mem_model_i.mem[ea] = c.ov;
        mrx_mem_model_i.mem[nxt] = {5'h14 | 5'h01, nxt[6:0]};
        t0 = -1;
        t1 = -1;
        apb(1'b1, 8'h08, 32'h080);
        apb(1'b1, 8'h0C, {19'h0, acl});
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h08, 32'hFFF);
        for (i = 0; i < 400 && t1 < 0; i++)
            @(posedge clk);
        if (t1 < 0)
            hang();
        if (lat == 4'h0)
            check(t1 - t0, 2 * exp_n(c.ins));
        apb(1'b1, 8'h00, 32'h0);
        for (i = 0; i < 50; i++)
        begin
            apb(1'b0, 8'h04, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        if (i == 50)
            hang();
        check({27'h0, rd[8:4]}, 32'h0A);
        eacl = exp_acl(c.ins, acl, c.ov);
        check({31'h0, rd[3]}, {31'h0, eacl[12]});
        apb(1'b0, 8'h08, 32'h0);
        check(rd, {20'h0, nxt});
        apb(1'b0, 8'h0C, 32'h0);
        check(rd, {19'h0, eacl});
        if (op < 3'h6)
            check({20'h0, mrx_mem_model_i.mem[ea]}, {20'h0, em});
        if (ind)
            check({20'h0, mrx_mem_model_i.mem[da]}, {20'h0, pv});
        $display("test %0d latency %0d done", n, lat);
    endtask : run_case
    // Main sequence: register checks, then every instruction at two memory speeds.
    initial
    begin
        srst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        lat <= 4'h0;
        tbl = '{'{12'h020, 12'h000, 12'hF0F, 13'h0000, 1'b1},
            '{12'h290, 12'h000, 12'h001, 13'h0FFF, 1'b0}, '{12'h30F, 12'hFFF, 12'h005, 13'h1001, 1'b0},
            '{12'h530, 12'h200, 12'hFFF, 13'h0000, 1'b1}, '{12'h4A5, 12'h000, 12'h7FF, 13'h0000, 1'b1},
            '{12'h708, 12'h1FF, 12'h000, 13'h0000, 1'b1}, '{12'h8A0, 12'h000, 12'h000, 13'h0000, 1'b1},
            '{12'hB10, 12'h123, 12'h000, 13'h0000, 1'b1}, '{12'h1C0, 12'h345, 12'h0F0, 13'h0000, 1'b1},
            '{12'hC00, 12'h000, 12'h000, 13'h0000, 1'b1}, '{12'hE00, 12'h000, 12'h000, 13'h0000, 1'b1},
            '{12'hE02, 12'h000, 12'h000, 13'h0000, 1'b1}, '{12'h90A, 12'h2FF, 12'h000, 13'h0000, 1'b1},
            '{12'hF02, 12'h000, 12'h000, 13'h0000, 1'b1}};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (k = 0; k < 8; k++)
        begin
            apb(1'b0, 8'(k * 4), 32'h0);
            check(rd, 32'h0);
            check({31'h0, err}, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b0, 8'h06, 32'h0);
        check({31'h0, err}, 32'h1);
        r = rnd32();
        apb(1'b1, 8'h10, r);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, {20'h0, r[11:0]});
        apb(1'b1, 8'h14, 32'hFFF);
        apb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
        $display("test register map done");
        for (m = 0; m < 2; m++)
        begin
            @(posedge clk);
            lat <= (m == 0) ? 4'h0 : 4'h3;
            for (k = 0; k < 14; k++)
                run_case(k);
        end
        end_of_test();
    end
endmodule : mrx_mem_ref_exec_test
`default_nettype wire

// *** logic/mrx_mem_ref_exec.sv ***
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mrx_regs.svh"
module mrx_mem_ref_exec
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output mrx_pkg::mrx_mem_req_t mem_req,
    input wire mrx_pkg::mrx_mem_rsp_t mem_rsp
);
    // ============================================================
    // Helper functions.
    // Opcode field of an instruction word.
    function automatic logic [2:0] op_of(input logic [11:0] w);
        op_of = w[11:9];
    endfunction : op_of

    // Direct address from the operand field and the current page, or page zero when the page bit is clear.
    // page and offset
    function automatic logic [11:0] direct_ea(input logic [11:0] w, input logic [11:0] memory_address_reg);
        if (w[`MRX_PAGESEL_POS])
            direct_ea = {memory_address_reg[`MRX_PAGE_MSB:`MRX_PAGE_LSB], w[`MRX_OFFS_MSB:0]};
        else
            direct_ea = {5'h00, w[`MRX_OFFS_MSB:0]};
    endfunction : direct_ea

    // True for the autoindexed pointer locations.
    function automatic logic is_auto(input logic [11:0] a);
        is_auto = (a >= `MRX_AUTO_LO) && (a <= `MRX_AUTO_HI);
    endfunction : is_auto

    // Number of states that an instruction occupies.
    function automatic logic [4:0] states_for(input logic [11:0] w, input logic [11:0] ea);
        logic [4:0] base;
        base = `MRX_ST_BASIC;
        unique case (op_of(w))
            `MRX_OP_INCSKP: base = `MRX_ST_INCSKP;
            `MRX_OP_DEPCLR, `MRX_OP_CALL: base = `MRX_ST_STORE;
            `MRX_OP_IOX: base = `MRX_ST_IOX;
            `MRX_OP_OPER:
            begin
                if (!w[`MRX_INDIRECT_POS] && (w[3:1] != 3'h0))
                    base = `MRX_ST_OPER_LONG;
            end
            default: base = `MRX_ST_BASIC;
        endcase
        if (op_of(w) < `MRX_OP_IOX && w[`MRX_INDIRECT_POS])
        begin
            if (is_auto(ea))
                base = base + `MRX_ST_AUTO_EXTRA;
            else
                base = base + `MRX_ST_IND_EXTRA;
        end
        states_for = base;
    endfunction : states_for

    // Read or write request words.
    function automatic mrx_pkg::mrx_mem_req_t mreq(input logic wr, input logic [11:0] a,
                                                   input logic [11:0] d);
        mreq = '{valid: 1'b1, write: wr, addr: a, wdata: d};
    endfunction : mreq

    // ============================================================
    // State.
    mrx_pkg::mrx_state_t state_r;
    mrx_pkg::mrx_mem_req_t mem_req_r;
    logic [11:0] pc_r;
    logic [11:0] ac_r;
    logic link_r;
    logic [11:0] mq_r;
    logic [11:0] mar_r;
    logic [11:0] ir_r;
    logic [11:0] ea_r;
    logic [4:0] budget_r;
    logic [7:0] cnt_r;
    logic run_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic apb_wr;
    logic reg_hit;
    logic [11:0] fetch_ea;
    logic [12:0] add_sum;
    logic [11:0] rd_inc;
    logic [7:0] pad_end;

    assign apb_wr = psel && penable && pwrite && pready_r;
    assign reg_hit = (paddr[1:0] == 2'h0) && (paddr <= `MRX_OFF_EA);
    assign fetch_ea = direct_ea(mem_rsp.rdata, mar_r);
    assign add_sum = {1'b0, ac_r} + {1'b0, mem_rsp.rdata};
    assign rd_inc = mem_rsp.rdata + 12'h001;
    assign pad_end = 8'({budget_r, 1'b0}) - 8'h02;

    // ============================================================
    // Bus slave: one wait state, then data and error from flops.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= psel && penable && !pready_r;
            if (psel && penable && !pready_r)
            begin
                pslverr_r <= !reg_hit;
                prdata_r <= 32'h0000_0000;
                unique case (paddr)
                    `MRX_OFF_CTRL: prdata_r <= {31'h0, run_r};
                    `MRX_OFF_STATUS: prdata_r <= {23'h0, budget_r, link_r, 2'h0,
                                                 state_r != mrx_pkg::MRX_IDLE};
                    `MRX_OFF_PC: prdata_r <= {20'h0, pc_r};
                    `MRX_OFF_AC: prdata_r <= {19'h0, link_r, ac_r};
                    `MRX_OFF_MQ: prdata_r <= {20'h0, mq_r};
                    `MRX_OFF_IR: prdata_r <= {20'h0, ir_r};
                    `MRX_OFF_MAR: prdata_r <= {20'h0, mar_r};
                    `MRX_OFF_EA: prdata_r <= {20'h0, ea_r};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Run control and the software-only quotient register.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            run_r <= 1'b0;
            mq_r <= `MRX_RST_WORD;
        end
        else if (apb_wr)
        begin
            if (paddr == `MRX_OFF_CTRL)
                run_r <= pwdata[`MRX_CTRL_RUN_BIT];
            if (paddr == `MRX_OFF_MQ)
                mq_r <= pwdata[11:0];
        end
    end

    // ============================================================
    // Cycle counter from the start of each instruction.
    // two clocks per state
    always_ff @(posedge clk)
    begin
        if (srst)
            cnt_r <= 8'h00;
        else if (state_r == mrx_pkg::MRX_IDLE)
            cnt_r <= 8'h00;
        else if (cnt_r != 8'hFF)
            cnt_r <= cnt_r + 8'h01;
    end

    // ============================================================
    // Instruction sequencer and datapath.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= mrx_pkg::MRX_IDLE;
            mem_req_r <= '0;
            pc_r <= `MRX_RST_WORD;
            ac_r <= `MRX_RST_WORD;
            link_r <= 1'b0;
            mar_r <= `MRX_RST_WORD;
            ir_r <= `MRX_RST_WORD;
            ea_r <= `MRX_RST_WORD;
            budget_r <= 5'h00;
        end
        else
        begin
            unique case (state_r)
                mrx_pkg::MRX_IDLE:
                begin
                    if (run_r)
                    begin
                        mar_r <= pc_r;
                        pc_r <= pc_r + 12'h001;
                        mem_req_r <= mreq(1'b0, pc_r, 12'h000);
                        state_r <= mrx_pkg::MRX_FETCH;
                    end
                    else if (apb_wr && paddr == `MRX_OFF_PC)
                        pc_r <= pwdata[11:0];
                    else if (apb_wr && paddr == `MRX_OFF_AC)
                    begin
                        ac_r <= pwdata[11:0];
                        link_r <= pwdata[`MRX_AC_LINK_BIT];
                    end
                end
                mrx_pkg::MRX_FETCH:
                begin
                    if (mem_rsp.ack)
                    begin
                        ir_r <= mem_rsp.rdata;
                        budget_r <= states_for(mem_rsp.rdata, fetch_ea);
                        ea_r <= fetch_ea;
                        mem_req_r <= '0;
                        if (op_of(mem_rsp.rdata) >= `MRX_OP_IOX)
                            state_r <= mrx_pkg::MRX_PAD;
                        else if (mem_rsp.rdata[`MRX_INDIRECT_POS])
                        begin
                            mem_req_r <= mreq(1'b0, fetch_ea, 12'h000);
                            state_r <= mrx_pkg::MRX_PTR;
                        end
                        else
                            state_r <= mrx_pkg::MRX_EXEC;
                    end
                end
                mrx_pkg::MRX_PTR:
                begin
                    if (mem_rsp.ack)
                    begin
                        if (is_auto(ea_r))
                        begin
                            ea_r <= rd_inc;
                            mem_req_r <= mreq(1'b1, ea_r, rd_inc);
                            state_r <= mrx_pkg::MRX_AUTOWR;
                        end
                        else
                        begin
                            ea_r <= mem_rsp.rdata;
                            mem_req_r <= '0;
                            state_r <= mrx_pkg::MRX_EXEC;
                        end
                    end
                end
                mrx_pkg::MRX_AUTOWR:
                begin
                    if (mem_rsp.ack)
                    begin
                        mem_req_r <= '0;
                        state_r <= mrx_pkg::MRX_EXEC;
                    end
                end
                mrx_pkg::MRX_EXEC:
                begin
                    unique case (op_of(ir_r))
                        `MRX_OP_AND, `MRX_OP_ADD, `MRX_OP_INCSKP:
                        begin
                            mem_req_r <= mreq(1'b0, ea_r, 12'h000);
                            state_r <= mrx_pkg::MRX_OPRD;
                        end
                        `MRX_OP_DEPCLR:
                        begin
                            mem_req_r <= mreq(1'b1, ea_r, ac_r);
                            state_r <= mrx_pkg::MRX_OPWR;
                        end
                        `MRX_OP_CALL:
                        begin
                            mem_req_r <= mreq(1'b1, ea_r, pc_r);
                            state_r <= mrx_pkg::MRX_OPWR;
                        end
                        default:
                        begin
                            pc_r <= ea_r;
                            state_r <= mrx_pkg::MRX_PAD;
                        end
                    endcase
                end
                mrx_pkg::MRX_OPRD:
                begin
                    if (mem_rsp.ack)
                    begin
                        mem_req_r <= '0;
                        state_r <= mrx_pkg::MRX_PAD;
                        unique case (op_of(ir_r))
                            `MRX_OP_AND: ac_r <= ac_r & mem_rsp.rdata;
                            `MRX_OP_ADD:
                            begin
                                ac_r <= add_sum[11:0];
                                link_r <= link_r ^ add_sum[12];
                            end
                            default:
                            begin
                                mem_req_r <= mreq(1'b1, ea_r, rd_inc);
                                state_r <= mrx_pkg::MRX_OPWR;
                                if (rd_inc == 12'h000)
                                    pc_r <= pc_r + 12'h001;
                            end
                        endcase
                    end
                end
                mrx_pkg::MRX_OPWR:
                begin
                    if (mem_rsp.ack)
                    begin
                        mem_req_r <= '0;
                        state_r <= mrx_pkg::MRX_PAD;
                        if (op_of(ir_r) == `MRX_OP_DEPCLR)
                            ac_r <= 12'h000;
                        if (op_of(ir_r) == `MRX_OP_CALL)
                            pc_r <= ea_r + 12'h001;
                    end
                end
                mrx_pkg::MRX_PAD:
                begin
                    if (cnt_r >= pad_end)
                        state_r <= mrx_pkg::MRX_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Outputs straight from flops.
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign mem_req = mem_req_r;

    // ============================================================
    // Checks.
    sequence s_fetch_go;
        state_r == mrx_pkg::MRX_IDLE && run_r;
    endsequence
    sequence s_fetched;
        state_r == mrx_pkg::MRX_FETCH && mem_rsp.ack && op_of(mem_rsp.rdata) < `MRX_OP_IOX;
    endsequence
    sequence s_rd_done(logic [2:0] op);
        state_r == mrx_pkg::MRX_OPRD && mem_rsp.ack && op_of(ir_r) == op;
    endsequence

    AST_FETCH_STEP: assert property (@(posedge clk) disable iff (srst)
        s_fetch_go |=> mar_r == $past(pc_r) && pc_r == $past(pc_r) + 12'h001
            && mem_req_r.valid && !mem_req_r.write && mem_req_r.addr == mar_r)
        else $error("Fetch did not copy and advance the counter.");

    AST_PAGE_FORM: assert property (@(posedge clk) disable iff (srst)
        s_fetched |=> ea_r == (ir_r[`MRX_PAGESEL_POS] ? {mar_r[11:7], ir_r[6:0]}
            : {5'h00, ir_r[6:0]}))
        else $error("Effective address page is wrong.");

    AST_INDIRECT: assert property (@(posedge clk) disable iff (srst)
        s_fetched ##0 mem_rsp.rdata[`MRX_INDIRECT_POS] |=> state_r == mrx_pkg::MRX_PTR
            && mem_req_r.valid && !mem_req_r.write && mem_req_r.addr == ea_r)
        else $error("Indirect pointer was not read.");

    AST_AUTOINDEX: assert property (@(posedge clk) disable iff (srst)
        state_r == mrx_pkg::MRX_PTR && mem_rsp.ack && is_auto(ea_r) |=> mem_req_r.write
            && mem_req_r.wdata == $past(mem_rsp.rdata) + 12'h001 && ea_r == mem_req_r.wdata)
        else $error("Autoindex pointer not incremented and restored.");

    AST_AND: assert property (@(posedge clk) disable iff (srst)
        s_rd_done(`MRX_OP_AND) |=> ac_r == ($past(ac_r) & $past(mem_rsp.rdata)))
        else $error("Logical and result wrong.");

    AST_ADD: assert property (@(posedge clk) disable iff (srst)
        s_rd_done(`MRX_OP_ADD) |=> {link_r ^ $past(link_r), ac_r}
            == {1'b0, $past(ac_r)} + {1'b0, $past(mem_rsp.rdata)})
        else $error("Add or link toggle wrong.");

    AST_INC_SKIP: assert property (@(posedge clk) disable iff (srst)
        s_rd_done(`MRX_OP_INCSKP) ##0 mem_rsp.rdata == 12'hFFF
            |=> pc_r == $past(pc_r) + 12'h001
            && mem_req_r.write && mem_req_r.wdata == 12'h000)
        else $error("Increment and skip failed.");

    AST_DEPOSIT: assert property (@(posedge clk) disable iff (srst)
        state_r == mrx_pkg::MRX_EXEC && op_of(ir_r) == `MRX_OP_DEPCLR
            |=> mem_req_r.write && mem_req_r.wdata == $past(ac_r))
        else $error("Deposit did not store the accumulator.");

    AST_DEPOSIT_CLR: assert property (@(posedge clk) disable iff (srst)
        state_r == mrx_pkg::MRX_OPWR && mem_rsp.ack && op_of(ir_r) == `MRX_OP_DEPCLR
            |=> ac_r == 12'h000)
        else $error("Deposit did not clear the accumulator.");

    AST_CALL: assert property (@(posedge clk) disable iff (srst)
        state_r == mrx_pkg::MRX_OPWR && mem_rsp.ack && op_of(ir_r) == `MRX_OP_CALL
            |=> pc_r == ea_r + 12'h001 && $stable(ac_r) && $stable(link_r) && $stable(mq_r))
        else $error("Subroutine call state wrong.");

    AST_BRANCH: assert property (@(posedge clk) disable iff (srst)
        state_r == mrx_pkg::MRX_EXEC && op_of(ir_r) == `MRX_OP_BRANCH |=> pc_r == $past(ea_r))
        else $error("Branch target not loaded.");

    AST_LENGTH: assert property (@(posedge clk) disable iff (srst)
        state_r == mrx_pkg::MRX_PAD ##1 state_r == mrx_pkg::MRX_IDLE
            |-> cnt_r + 8'h01 >= 8'({budget_r, 1'b0}))
        else $error("Instruction ended before its state count.");
endmodule : mrx_mem_ref_exec
`default_nettype wire

// *** logic/mrx_pkg.sv ***
// ============================================================
// Shared types.
package mrx_pkg;
    typedef enum {
        MRX_IDLE, MRX_FETCH, MRX_PTR, MRX_AUTOWR, MRX_EXEC, MRX_OPRD, MRX_OPWR, MRX_PAD
    } mrx_state_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [11:0] wdata;
    } mrx_mem_req_t;
    typedef struct packed {
        logic ack;
        logic [11:0] rdata;
    } mrx_mem_rsp_t;
endpackage : mrx_pkg

// *** logic/mrx_regs.svh ***
`ifndef MRX_REGS_SVH
`define MRX_REGS_SVH
// ============================================================
// Register offsets on the bus.
`define MRX_OFF_CTRL 8'h00
`define MRX_OFF_STATUS 8'h04
`define MRX_OFF_PC 8'h08
`define MRX_OFF_AC 8'h0C
`define MRX_OFF_MQ 8'h10
`define MRX_OFF_IR 8'h14
`define MRX_OFF_MAR 8'h18
`define MRX_OFF_EA 8'h1C
// ============================================================
// Field positions and reset values.
`define MRX_CTRL_RUN_BIT 0
`define MRX_AC_LINK_BIT 12
`define MRX_RST_WORD 12'h000
// ============================================================
// Address and instruction layout.
`define MRX_PAGE_MSB 11
`define MRX_PAGE_LSB 7
`define MRX_OFFS_MSB 6
`define MRX_INDIRECT_POS 8
`define MRX_PAGESEL_POS 7
`define MRX_AUTO_LO 12'h008
`define MRX_AUTO_HI 12'h00F
// ============================================================
// Opcodes.
`define MRX_OP_AND 3'h0
`define MRX_OP_ADD 3'h1
`define MRX_OP_INCSKP 3'h2
`define MRX_OP_DEPCLR 3'h3
`define MRX_OP_CALL 3'h4
`define MRX_OP_BRANCH 3'h5
`define MRX_OP_IOX 3'h6
`define MRX_OP_OPER 3'h7
// ============================================================
// State counts and clock periods per state.
`define MRX_ST_BASIC 5'h0A
`define MRX_ST_INCSKP 5'h10
`define MRX_ST_STORE 5'h0B
`define MRX_ST_IOX 5'h11
`define MRX_ST_OPER_LONG 5'h0F
`define MRX_ST_IND_EXTRA 5'h05
`define MRX_ST_AUTO_EXTRA 5'h06
`define MRX_CLK_PER_STATE 2
`endif
